/* pad_pkg.sv */
package pad_pkg;
  localparam int          STAGES        = 9;
  localparam int          STAGE_BITS    = 2;
  localparam int          CODE_W        = STAGES * STAGE_BITS;
  localparam int          RES_BITS      = 10;
  localparam int          SUM_W         = 11;
  localparam int          LAT_HALF      = 13;
  localparam int          ALIGN_EXTRA   = LAT_HALF - STAGES;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          CLK_MHZ       = 1000 / CLK_PERIOD_NS;
  localparam int          MSB_POS       = RES_BITS - 1;
  localparam logic [9:0]  RES_MAX       = 10'h3FF;
  localparam logic [9:0]  RES_RST       = 10'h000;
endpackage : pad_pkg

/* pad_core.sv */
`timescale 1ns/100ps

module pad_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           wr_en = in_valid && in_ready;
  wire           rd_en = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (wr_en) mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_en) wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      if (rd_en) rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!nrst)
    cnt_q <= (AW+1)'(D))
    else $error("fifo count above depth");
  a_fifo_full_hold: assert property (@(posedge clk) disable iff (!nrst)
    (!in_ready && !out_ready) |=> !in_ready)
    else $error("full flag dropped without read");
endmodule : pad_fifo

module pad_core
  import pad_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         conv_clk,
  input  wire logic [pad_pkg::CODE_W-1:0]   stage_code,
  input  wire logic                         coding_select,
  input  wire logic                         output_enable_n,
  output logic      [pad_pkg::RES_BITS-1:0] result,
  output logic                              result_oe,
  output logic                              result_valid,
  input  wire logic                         result_ready,
  output logic                              sample_phase,
  output logic                              hold_phase,
  output logic                              overflow
);
  import pad_pkg::*;

  // two-flop synchronisers; the first stage feeds only the second
  logic              ck1_q, ck2_q, ck3_q;
  logic [CODE_W-1:0] code1_q, code2_q;
  logic              sel1_q, sel2_q, oen1_q, oen2_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {ck1_q, ck2_q, ck3_q}   <= 3'h0;
      {code1_q, code2_q}      <= '0;
      {sel1_q, sel2_q}        <= 2'h0;
      {oen1_q, oen2_q}        <= 2'h3;
    end else begin
      {ck1_q, ck2_q, ck3_q}   <= {conv_clk, ck1_q, ck2_q};
      {code1_q, code2_q}      <= {stage_code, code1_q};
      {sel1_q, sel2_q}        <= {coding_select, sel1_q};
      {oen1_q, oen2_q}        <= {output_enable_n, oen1_q};
    end
  end

  wire ev      = ck2_q ^ ck3_q;
  wire ev_fall = ev && !ck2_q;

  logic [STAGE_BITS-1:0] aligned [STAGES];
  logic [SUM_W-1:0]      psum [STAGES+1];
  assign psum[0] = '0;

  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    localparam int LEN = STAGES - 1 - i + ALIGN_EXTRA;
    logic [STAGE_BITS-1:0] line_q [LEN];
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        for (int k = 0; k < LEN; k++) line_q[k] <= '0;
      end else if (ev) begin
        line_q[0] <= code2_q[i*STAGE_BITS +: STAGE_BITS];
        for (int k = 1; k < LEN; k++) line_q[k] <= line_q[k-1];
      end
    end
    assign aligned[i] = line_q[LEN-1];
    a_line_shift: assert property (@(posedge clk) disable iff (!nrst)
      ev |=> (line_q[0] == $past(code2_q[i*STAGE_BITS +: STAGE_BITS])))
      else $error("stage code not captured");
    a_line_still: assert property (@(posedge clk) disable iff (!nrst)
      !ev |=> $stable(line_q[LEN-1]))
      else $error("delay line moved between events");
    // overlapping weights: adjacent stages share one redundant bit
    assign psum[i+1] = psum[i] + (SUM_W'(aligned[i]) << (STAGES - 1 - i));
  end

  wire [SUM_W-1:0]    sum_w  = psum[STAGES];
  wire                over_w = (sum_w > SUM_W'(RES_MAX));
  wire [RES_BITS-1:0] sat_w  = over_w ? RES_MAX : sum_w[RES_BITS-1:0];
  wire [RES_BITS-1:0] msb_w  = {sel2_q, {(RES_BITS-1){1'b0}}};
  wire [RES_BITS-1:0] code_w = sat_w ^ msb_w;

  wire                push = ev_fall;
  wire                f_ready;
  wire                f_valid;
  wire [RES_BITS-1:0] f_data;
  wire                take = f_valid && (!result_valid || result_ready);

  pad_fifo #(.W(RES_BITS), .D(DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (code_w),
    .out_valid (f_valid),
    .out_ready (take),
    .out_data  (f_data)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result       <= RES_RST;
      result_valid <= 1'b0;
      result_oe    <= 1'b0;
      sample_phase <= 1'b0;
      hold_phase   <= 1'b0;
      overflow     <= 1'b0;
    end else begin
      if (take) result <= f_data;
      result_valid <= take || (result_valid && !result_ready);
      result_oe    <= !oen2_q;
      sample_phase <= ck2_q && ck3_q;
      hold_phase   <= !ck2_q && !ck3_q;
      overflow     <= overflow || (push && !f_ready);
    end
  end

  // phase, coding and output word checks
  a_phase_nonoverlap: assert property (@(posedge clk) disable iff (!nrst)
    !(sample_phase && hold_phase))
    else $error("phases overlap");
  a_phase_follow: assert property (@(posedge clk) disable iff (!nrst)
    (ck2_q && ck3_q) |=> sample_phase)
    else $error("sample phase missing");
  a_hold_follow: assert property (@(posedge clk) disable iff (!nrst)
    (!ck2_q && !ck3_q) |=> hold_phase)
    else $error("hold phase missing");
  a_push_on_fall: assert property (@(posedge clk) disable iff (!nrst)
    push |-> (ck3_q && !ck2_q))
    else $error("push not on falling edge");
  a_rise_no_push: assert property (@(posedge clk) disable iff (!nrst)
    (ev && ck2_q) |-> !push)
    else $error("push on rising edge");
  a_edge_event: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(ck3_q) || $fell(ck3_q)) |-> $past(ev))
    else $error("edge missed");
  a_sat_top: assert property (@(posedge clk) disable iff (!nrst)
    (sum_w > SUM_W'(RES_MAX)) |-> (sat_w == RES_MAX))
    else $error("no saturation");
  a_sat_pass: assert property (@(posedge clk) disable iff (!nrst)
    (sum_w <= SUM_W'(RES_MAX)) |-> (sat_w == sum_w[RES_BITS-1:0]))
    else $error("in-range word altered");
  a_offset_binary: assert property (@(posedge clk) disable iff (!nrst)
    !sel2_q |-> (code_w == sat_w))
    else $error("offset binary wrong");
  a_twos_msb: assert property (@(posedge clk) disable iff (!nrst)
    sel2_q |-> (code_w == {~sat_w[MSB_POS], sat_w[MSB_POS-1:0]}))
    else $error("msb not inverted");
  a_oe_follow: assert property (@(posedge clk) disable iff (!nrst)
    oen2_q |=> !result_oe)
    else $error("outputs not disabled");
  a_oe_drive: assert property (@(posedge clk) disable iff (!nrst)
    !oen2_q |=> result_oe)
    else $error("outputs not enabled");
  a_out_hold: assert property (@(posedge clk) disable iff (!nrst)
    (result_valid && !result_ready) |=> (result_valid && $stable(result)))
    else $error("result changed under stall");
  a_out_load: assert property (@(posedge clk) disable iff (!nrst)
    take |=> (result_valid && (result == $past(f_data))))
    else $error("word not loaded");
  a_sum_weight: assert property (@(posedge clk) disable iff (!nrst)
    (sum_w <= SUM_W'(((1 << STAGES) - 1) * ((1 << STAGE_BITS) - 1))))
    else $error("sum out of range");
  a_drop_flag: assert property (@(posedge clk) disable iff (!nrst)
    (push && !f_ready) |=> overflow)
    else $error("dropped word not flagged");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
    overflow |=> overflow)
    else $error("overflow cleared");

  c_push:       cover property (@(posedge clk) disable iff (!nrst) push && f_ready);
  c_sat:        cover property (@(posedge clk) disable iff (!nrst) push && over_w);
  c_twos:       cover property (@(posedge clk) disable iff (!nrst) push && sel2_q);
  c_backpres:   cover property (@(posedge clk) disable iff (!nrst) push && !f_ready);
  c_drain_full: cover property (@(posedge clk) disable iff (!nrst) !f_ready && take);
endmodule : pad_core

/* pad_dummy_none.sv */
`timescale 1ns/100ps

/* pad_sink.sv */
`timescale 1ns/100ps
module pad_sink
  import pad_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [pad_pkg::RES_BITS-1:0] result,
  input  wire logic                         result_oe,
  input  wire logic                         result_valid,
  output logic                              result_ready,
  input  wire logic                         stall,
  output logic      [pad_pkg::RES_BITS-1:0] last_word,
  output int                                n_words
);
  // floating pins when the outputs are disabled
  wire [RES_BITS-1:0] pins = result_oe ? result : {RES_BITS{1'bz}};
  assign result_ready = !stall;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_word <= '0;
      n_words <= 0;
    end else if (result_valid && result_ready) begin
      last_word <= pins;
      n_words <= n_words + 1;
    end
  end
endmodule : pad_sink

/* pipelined_adc_digital_output_test.sv */
`timescale 1ns/100ps
module pipelined_adc_digital_output_test;
  import pad_pkg::*;
  logic                clk, nrst, conv_clk, coding_select, output_enable_n, stall;
  logic                result_oe, result_valid, result_ready;
  logic                sample_phase, hold_phase, overflow;
  logic [CODE_W-1:0]   stage_code;
  logic [RES_BITS-1:0] result, last_word;
  int                  n_words, errors, n_tests, n0;

  pad_core u_dut (.clk(clk), .nrst(nrst), .conv_clk(conv_clk), .stage_code(stage_code),
    .coding_select(coding_select), .output_enable_n(output_enable_n), .result(result),
    .result_oe(result_oe), .result_valid(result_valid), .result_ready(result_ready),
    .sample_phase(sample_phase), .hold_phase(hold_phase), .overflow(overflow));
  pad_sink u_sink (.clk(clk), .nrst(nrst), .result(result), .result_oe(result_oe),
    .result_valid(result_valid), .result_ready(result_ready), .stall(stall),
    .last_word(last_word), .n_words(n_words));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // equal halves keep the convert clock at even duty
  task automatic step(input int n);
    repeat (n) begin
      wait_clk(4);
      conv_clk = ~conv_clk;
      wait_clk(4);
    end
  endtask : step

  function automatic logic [9:0] exp_word(input int c, input logic sel);
    int s;
    s = c * 511;
    if (s > 1023) s = 1023;
    return 10'(s) ^ {sel, 9'h000};
  endfunction : exp_word

  task automatic t_coding;
    for (int sel = 0; sel < 2; sel++) begin
      for (int c = 0; c < 4; c++) begin
        coding_select = sel[0];
        stage_code = {STAGES{c[1:0]}};
        step(28);
        wait_clk(3);
        chk(last_word === exp_word(c, sel[0]), "coded word");
      end
    end
  endtask : t_coding

  task automatic t_latency;
    coding_select = 1'b0;
    stage_code = '0;
    step(30);
    stage_code = {STAGES{2'h1}};
    step(12);
    wait_clk(3);
    chk(last_word === 10'h0FF, "partial word before latency");
    step(2);
    wait_clk(3);
    chk(last_word === 10'h1FF, "full word at latency");
  endtask : t_latency

  task automatic t_overflow;
    chk(overflow === 1'b0, "overflow at start");
    stall = 1'b1;
    step(40);
    chk(overflow === 1'b1, "overflow after stall");
    n0 = n_words;
    stall = 1'b0;
    wait_clk(40);
    chk(result_valid === 1'b0 && n_words - n0 >= FIFO_DEPTH, "drain");
  endtask : t_overflow

  task automatic t_phase_oe;
    wait_clk(4);
    conv_clk = 1'b1;
    wait_clk(7);
    chk(sample_phase === 1'b1 && hold_phase === 1'b0, "sample phase");
    conv_clk = 1'b0;
    wait_clk(7);
    chk(hold_phase === 1'b1 && sample_phase === 1'b0, "hold phase");
    output_enable_n = 1'b1;
    wait_clk(5);
    chk(result_oe === 1'b0, "outputs disabled");
    output_enable_n = 1'b0;
    wait_clk(5);
    chk(result_oe === 1'b1, "outputs enabled");
  endtask : t_phase_oe

  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  initial begin
    errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    conv_clk = 1'b0;
    coding_select = 1'b0;
    output_enable_n = 1'b0;
    stall = 1'b0;
    stage_code = '0;
    wait_clk(2);
    chk(result_valid === 1'b0 && result_oe === 1'b0, "reset outputs");
    nrst = 1'b1;
    t_phase_oe();
    t_coding();
    t_latency();
    t_overflow();
    end_sim();
  end
endmodule : pipelined_adc_digital_output_test
